// ---- shared/spm_consts.vh ----
// Purpose: shared constants of the scan packet master and its test access port
// Assumes: 32-bit apb data, one word per register
// Notes: offsets are byte addresses
`ifndef SPM_CONSTS_VH
`define SPM_CONSTS_VH
// register byte offsets
`define SPM_OFF_CFG 12'h000
`define SPM_OFF_STAT 12'h004
`define SPM_OFF_TMS_UP 12'h008
`define SPM_OFF_TMS_LO 12'h00C
`define SPM_OFF_TDI_UP 12'h010
`define SPM_OFF_TDI_LO 12'h014
`define SPM_OFF_TDO_UP 12'h018
`define SPM_OFF_TDO_LO 12'h01C
`define SPM_OFF_IDCODE 12'h020
// configuration fields
`define SPM_CFG_DIV_LSB 0
`define SPM_CFG_DIV_W 3
`define SPM_CFG_COMP_BIT 4
`define SPM_CFG_DTM_BIT 5
`define SPM_CFG_EVT_BIT 6
`define SPM_CFG_SRC_BIT 7
`define SPM_CFG_RESET 32'h0000_0000
// status fields
`define SPM_STAT_IDLE_BIT 0
`define SPM_STAT_DONE_BIT 1
// packet and tap figures
`define SPM_PKT_LEN 7'd60
`define SPM_IR_W 6
`define SPM_IR_IDCODE 6'h01
`define SPM_IR_CAPTURE 6'h01
`define SPM_IR_BYPASS 6'h3F
`define SPM_IDCODE_VAL 32'h1234_5671
`define SPM_PAT_RESET 32'h0000_0000
`endif

// ---- hw/spm_tap.v ----
// Purpose: internal test access port with a 6-bit instruction register
// Assumes: tck edges arrive as one-cycle enables of the system clock
// Notes: id value is arbitrary; only idcode and bypass select data registers
`include "spm_consts.vh"
module spm_tap (
    // clock and reset
    input wire clk,
    input wire rst,
    // scan edges and pins
    input wire tck_rise,
    input wire tck_fall,
    input wire tap_compliance_select,
    input wire tms,
    input wire tdi,
    output reg tdo,
    output reg tdo_oe_n
);
    // tap states, standard boundary-scan encoding of our own
    localparam TLR = 4'd0, RTI = 4'd1, SDS = 4'd2, CDR = 4'd3, SHDR = 4'd4, E1DR = 4'd5;
    localparam PDR = 4'd6, E2DR = 4'd7, UDR = 4'd8, SIS = 4'd9, CIR = 4'd10, SHIR = 4'd11;
    localparam E1IR = 4'd12, PIR = 4'd13, E2IR = 4'd14, UIR = 4'd15;
    reg [3:0] state; // current tap state
    reg [3:0] next_state; // state after the next rising tck
    reg [5:0] ir_shift; // instruction shifter
    reg [5:0] ir; // latched instruction
    reg [31:0] dr_shift; // data shifter, idcode is the widest register
    // the bypass path reuses bit 0 of the data shifter, so no separate flop
    reg [31:0] id_reg; // written through update-dr only
    wire held = ~tap_compliance_select; // held in reset when not enabled

    // next-state table driven by tms
    always @* begin
        case (state)
            TLR: next_state = tms ? TLR : RTI;
            RTI: next_state = tms ? SDS : RTI;
            SDS: next_state = tms ? SIS : CDR;
            CDR: next_state = tms ? E1DR : SHDR;
            SHDR: next_state = tms ? E1DR : SHDR;
            E1DR: next_state = tms ? UDR : PDR;
            PDR: next_state = tms ? E2DR : PDR;
            E2DR: next_state = tms ? UDR : SHDR;
            UDR: next_state = tms ? SDS : RTI;
            SIS: next_state = tms ? TLR : CIR;
            CIR: next_state = tms ? E1IR : SHIR;
            SHIR: next_state = tms ? E1IR : SHIR;
            E1IR: next_state = tms ? UIR : PIR;
            PIR: next_state = tms ? E2IR : PIR;
            E2IR: next_state = tms ? UIR : SHIR;
            UIR: next_state = tms ? SDS : RTI;
            default: next_state = TLR;
        endcase
    end

    // state, shifters sampled on rising tck
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= TLR;
            ir_shift <= 6'h00;
            dr_shift <= 32'h0000_0000;
        end else if (held) begin
            state <= TLR;
        end else if (tck_rise) begin
            state <= next_state;
            case (state)
                CIR: ir_shift <= `SPM_IR_CAPTURE;
                SHIR: ir_shift <= {tdi, ir_shift[5:1]};
                CDR: dr_shift <= (ir == `SPM_IR_IDCODE) ? id_reg : 32'h0000_0000;
                SHDR: begin
                    // lsb first; reader may stop at any time
                    if (ir == `SPM_IR_IDCODE)
                        dr_shift <= {tdi, dr_shift[31:1]};
                    else
                        dr_shift <= {31'h0000_0000, tdi};
                end
                default: ;
            endcase
        end
    end

    // instruction and data registers change on falling tck only
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            ir <= `SPM_IR_IDCODE; // asynchronous idcode load
            id_reg <= `SPM_IDCODE_VAL;
            tdo <= 1'b0;
            tdo_oe_n <= 1'b1;
        end else if (held) begin
            ir <= `SPM_IR_IDCODE;
            tdo_oe_n <= 1'b1;
        end else if (tck_fall) begin
            // only these two states may touch the instruction
            if (state == UIR)
                ir <= ir_shift;
            else if (state == TLR)
                ir <= `SPM_IR_IDCODE;
            // undefined opcodes behave as bypass, no side effect
            if (state == UDR && ir == `SPM_IR_IDCODE)
                id_reg <= dr_shift;
            // drive only in the two shift states
            tdo_oe_n <= ~(state == SHIR || state == SHDR);
            tdo <= (state == SHIR) ? ir_shift[0] : dr_shift[0];
        end
    end
    // registers are reachable only by shifting, no bus port
endmodule // spm_tap

// ---- hw/spm_master.v ----
// Purpose: apb-loaded scan packet master driving an internal test access port
// Assumes: apb slave, zero wait states; link inputs synchronous to clk
// Notes: one tck period spans 2*(div+1) clocks
//
// Operation
// - tck divided from system clock by select
// - drive stored tms/tdi for 60 cycles
// - sample tdo each cycle, readable words
// - only whole 60-cycle packets, idle tail
// - tms/tdi from 60 msbs of pairs
// - lsb of fourth word starts packet
// - status idle flag shows packet progress
// - patterns from apb or link, distinguished
// - tap samples tms/tdi on rising tck
// - tdo driven only in shift states
// - tap held reset unless compliance enabled
// - tap registers reachable only by shifting
// - 6-bit instruction resets to idcode
// - shift ir, latch on falling update-ir
// - instruction changes only update-ir or reset
// - idcode loads on falling tck or reset
// - capture-ir loads 000001b
// - standard state sequence from sampled tms
// - data registers shift lsb first
// - capture-dr loads, update-dr writes register
// - undefined opcodes are reserved
//
// Design decisions made here: the register addresses and the APB interface to the registers.
`include "spm_consts.vh"
module spm_master (
    // clock and reset
    input wire clk,
    input wire rst,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // parallel link side
    input wire link_valid,
    input wire [127:0] link_pattern,
    output reg link_done,
    output reg [63:0] link_capture,
    // scan pins seen from outside for observation
    output reg scan_tck,
    output reg scan_tms,
    output reg scan_tdi,
    output reg scan_busy
);
    // packet states
    localparam ST_IDLE = 2'd0, ST_LOW = 2'd1, ST_HIGH = 2'd2;
    reg [1:0] state; // packet state
    reg [31:0] cfg; // configuration register
    reg [31:0] tms_pattern_upper; // tms bits 59..28 of packet in 31..0
    reg [31:0] tms_pattern_lower;
    reg [31:0] tdi_pattern_upper;
    reg [31:0] tdi_pattern_lower_send; // bit 0 is the send trigger
    reg [31:0] tdo_capture_upper; // first captured bit at bit 31
    reg [31:0] tdo_capture_lower;
    reg [59:0] tms_sr; // working copy shifted out msb first
    reg [59:0] tdi_sr;
    reg [59:0] cap_sr; // captured tdo, msb first
    reg [6:0] cyc; // packet cycle count
    reg [2:0] div_cnt; // tck half-period divider
    reg done_flag; // last packet finished
    reg from_link; // source of the running packet
    reg tck_rise; // one-cycle enables toward the tap
    reg tck_fall;
    wire tdo_w; // tap serial output
    wire tdo_oe_n_w; // low while tap drives tdo
    wire [2:0] div_sel = cfg[`SPM_CFG_DIV_LSB+`SPM_CFG_DIV_W-1:`SPM_CFG_DIV_LSB];
    wire comp_en = cfg[`SPM_CFG_COMP_BIT];
    wire setup = psel & ~penable;
    wire wr = psel & penable & pwrite;

    // register read mux
    function [31:0] rd_mux;
        input [11:0] a;
        begin
            case (a)
                `SPM_OFF_CFG: rd_mux = cfg;
                `SPM_OFF_STAT: rd_mux = {30'h0000_0000, done_flag, state == ST_IDLE};
                `SPM_OFF_TMS_UP: rd_mux = tms_pattern_upper;
                `SPM_OFF_TMS_LO: rd_mux = tms_pattern_lower;
                `SPM_OFF_TDI_UP: rd_mux = tdi_pattern_upper;
                `SPM_OFF_TDI_LO: rd_mux = tdi_pattern_lower_send;
                `SPM_OFF_TDO_UP: rd_mux = tdo_capture_upper;
                `SPM_OFF_TDO_LO: rd_mux = tdo_capture_lower;
                default: rd_mux = 32'h0000_0000;
            endcase
        end
    endfunction

    // known offset check, used for slave error
    function mapped;
        input [11:0] a;
        begin
            mapped = (a[1:0] == 2'b00) && (a <= `SPM_OFF_TDO_LO);
        end
    endfunction

    // apb: one wait-free access phase, answer on its edge
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            // ready is raised in setup so the access phase ends at once
            pready <= setup;
            pslverr <= setup & ~mapped(paddr);
            if (setup && !pwrite)
                prdata <= rd_mux(paddr);
        end
    end

    // configuration and pattern registers; trigger start of packet
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cfg <= `SPM_CFG_RESET;
            tms_pattern_upper <= `SPM_PAT_RESET;
            tms_pattern_lower <= `SPM_PAT_RESET;
            tdi_pattern_upper <= `SPM_PAT_RESET;
            tdi_pattern_lower_send <= `SPM_PAT_RESET;
        end else if (wr && pready) begin
            // the compliance, transfer and event bits are software's duty
            case (paddr)
                `SPM_OFF_CFG: cfg <= pwdata;
                `SPM_OFF_TMS_UP: tms_pattern_upper <= pwdata;
                `SPM_OFF_TMS_LO: tms_pattern_lower <= pwdata;
                `SPM_OFF_TDI_UP: tdi_pattern_upper <= pwdata;
                `SPM_OFF_TDI_LO: tdi_pattern_lower_send <= pwdata;
                default: ;
            endcase
        end else if (state == ST_IDLE && link_valid && cfg[`SPM_CFG_SRC_BIT]) begin
            // link source overwrites the pattern words
            tms_pattern_upper <= link_pattern[127:96];
            tms_pattern_lower <= link_pattern[95:64];
            tdi_pattern_upper <= link_pattern[63:32];
            tdi_pattern_lower_send <= link_pattern[31:0];
        end
    end

    // trigger from either source while idle; a trigger mid-packet is ignored
    wire sw_go = wr && pready && paddr == `SPM_OFF_TDI_LO && pwdata[0]
        && !cfg[`SPM_CFG_SRC_BIT];
    wire link_go = link_valid && cfg[`SPM_CFG_SRC_BIT];
    wire half_end = (div_cnt == div_sel); // end of one tck half period

    // packet engine: each tck cycle is a low half then a high half
    // tms and tdi change only in the low half, so the tap sees them settled
    // a half period of div+1 clocks keeps the divider a plain 3-bit counter
    // limitation: the divider select is read live, so change it only while idle
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= ST_IDLE;
            div_cnt <= 3'd0;
            cyc <= 7'd0;
            tms_sr <= 60'h0;
            tdi_sr <= 60'h0;
            cap_sr <= 60'h0;
            done_flag <= 1'b0;
            from_link <= 1'b0;
            tck_rise <= 1'b0;
            tck_fall <= 1'b0;
            scan_tck <= 1'b0;
            scan_tms <= 1'b0;
            scan_tdi <= 1'b0;
            scan_busy <= 1'b0;
            tdo_capture_upper <= 32'h0000_0000;
            tdo_capture_lower <= 32'h0000_0000;
            link_done <= 1'b0;
            link_capture <= 64'h0;
        end else begin
            tck_rise <= 1'b0;
            tck_fall <= 1'b0;
            link_done <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (sw_go || link_go) begin
                        // 60 msbs of each pair
                        if (link_go) begin
                            tms_sr <= link_pattern[127:68];
                            tdi_sr <= link_pattern[63:4];
                        end else begin
                            tms_sr <= {tms_pattern_upper, tms_pattern_lower[31:4]};
                            tdi_sr <= {tdi_pattern_upper, pwdata[31:4]};
                        end
                        from_link <= link_go;
                        state <= ST_LOW;
                        cyc <= 7'd0;
                        div_cnt <= 3'd0;
                        done_flag <= 1'b0;
                        scan_busy <= 1'b1; // busy from the trigger
                    end
                end
                ST_LOW: begin
                    // present the level for this cycle
                    scan_tms <= tms_sr[59];
                    scan_tdi <= tdi_sr[59];
                    div_cnt <= half_end ? 3'd0 : div_cnt + 3'd1;
                    if (half_end) begin
                        scan_tck <= 1'b1;
                        tck_rise <= 1'b1; // tap samples here
                        state <= ST_HIGH;
                    end
                end
                ST_HIGH: begin
                    div_cnt <= half_end ? 3'd0 : div_cnt + 3'd1;
                    if (half_end) begin
                        scan_tck <= 1'b0;
                        tck_fall <= 1'b1;
                        // released tdo reads as one; sample once per cycle
                        // the tap moves tdo one clock after the fall enable, so this
                        // sample sees the bit shown since the previous fall
                        cap_sr <= {cap_sr[58:0], tdo_oe_n_w ? 1'b1 : tdo_w};
                        tms_sr <= {tms_sr[58:0], 1'b0};
                        tdi_sr <= {tdi_sr[58:0], 1'b0};
                        cyc <= cyc + 7'd1;
                        // exactly 60 cycles, unused tail set idle by software
                        if (cyc == `SPM_PKT_LEN - 7'd1) begin
                            state <= ST_IDLE;
                            done_flag <= 1'b1;
                            scan_busy <= 1'b0;
                        end else
                            state <= ST_LOW;
                    end
                end
                default: state <= ST_IDLE;
            endcase
            // capture words settle in the cycle after the last bit
            if (state == ST_IDLE && done_flag && scan_busy == 1'b0 && cyc == `SPM_PKT_LEN) begin
                tdo_capture_upper <= cap_sr[59:28];
                tdo_capture_lower <= {cap_sr[27:0], 4'h0};
                link_done <= from_link;
                link_capture <= {cap_sr, 4'h0};
                cyc <= 7'd0;
            end
        end
    end

    // internal test access port fed by the packet
    spm_tap u_tap (
        .clk(clk),
        .rst(rst),
        .tck_rise(tck_rise),
        .tck_fall(tck_fall),
        .tap_compliance_select(comp_en),
        .tms(scan_tms),
        .tdi(scan_tdi),
        .tdo(tdo_w),
        .tdo_oe_n(tdo_oe_n_w)
    );
endmodule // spm_master

// ---- verif/spm_master_sva.sv ----
// Purpose: port checker for the scan packet master
// Assumes: bound to spm_master, one clock domain
// Notes: link source bit is tracked from apb writes
`include "spm_consts.vh"
module spm_master_sva (
    // clock and reset
    input logic clk,
    input logic rst,
    // apb
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [11:0] paddr,
    input logic [31:0] pwdata,
    input logic [31:0] prdata,
    input logic pready,
    input logic pslverr,
    // link
    input logic link_valid,
    input logic [127:0] link_pattern,
    input logic link_done,
    input logic [63:0] link_capture,
    // scan pins
    input logic scan_tck,
    input logic scan_tms,
    input logic scan_tdi,
    input logic scan_busy
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic wr_acc; // write completing now
    logic src_link; // software send ignored when set
    logic tck_q; // tck one clock ago
    logic [6:0] n_rise; // tck rises in this packet
    assign wr_acc = psel && penable && pready && pwrite;
    // helper state follows the bus, counts rises per packet
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            src_link <= 1'b0;
            tck_q <= 1'b0;
            n_rise <= 7'd0;
        end else begin
            tck_q <= scan_tck;
            if (wr_acc && paddr == `SPM_OFF_CFG) src_link <= pwdata[`SPM_CFG_SRC_BIT];
            if (!scan_busy) n_rise <= 7'd0;
            else if (scan_tck && !tck_q) n_rise <= n_rise + 7'd1;
        end
    end
    AST_READY: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    AST_READY_ONE: assert property (pready |=> !pready)
        else $error("ready held too long");
    AST_ERR: assert property (pslverr |-> pready && (pwrite || prdata == 0))
        else $error("bad error answer");
    AST_SEND: assert property (wr_acc && paddr == `SPM_OFF_TDI_LO && pwdata[0]
        && !scan_busy && !src_link |=> ##[0:1] scan_busy) else $error("send lost");
    AST_NO_SEND: assert property (wr_acc && paddr == `SPM_OFF_TDI_LO && pwdata[0]
        && !scan_busy && src_link && !link_valid |=> !scan_busy) else $error("send taken");
    AST_HOLD: assert property (scan_busy && scan_tck && $past(scan_tck)
        |-> $stable(scan_tms) && $stable(scan_tdi)) else $error("pins moved in tck high");
    AST_COUNT: assert property ($fell(scan_busy) |-> n_rise == 7'd60)
        else $error("packet not 60 cycles");
    AST_TCK_IDLE: assert property ($rose(scan_tck) |-> scan_busy)
        else $error("tck outside packet");
    AST_LINK_PULSE: assert property (link_done |=> !link_done)
        else $error("done not a pulse");
endmodule // spm_master_sva

// ---- verif/spm_link_model.sv ----
// Purpose: model of the serial link module feeding patterns
// Assumes: master takes the offer while idle
// Notes: released pattern lines show inverted junk
module spm_link_model (
    // clock and reset
    input logic clk,
    input logic rst,
    // bench control
    input logic go,
    input logic [3:0] dly,
    input logic [127:0] pat,
    output logic got,
    output logic [63:0] cap,
    // master link side
    input logic scan_busy,
    input logic link_done,
    input logic [63:0] link_capture,
    output logic link_valid,
    output logic [127:0] link_pattern
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] wait_n; // delay before offering
    logic armed; // offer pending
    // offer after a delay, release once taken, keep capture
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            armed <= 1'b0;
            wait_n <= 4'h0;
            got <= 1'b0;
            cap <= '0;
            link_valid <= 1'b0;
            link_pattern <= '0;
        end else begin
            if (go) begin
                armed <= 1'b1;
                wait_n <= dly;
                got <= 1'b0;
            end else if (armed && wait_n != 4'h0) begin
                wait_n <= wait_n - 4'h1;
            end else if (armed) begin
                armed <= 1'b0;
                link_valid <= 1'b1;
                link_pattern <= pat;
            end
            // no pull on these lines, so show the inverse once released
            if (link_valid && scan_busy) begin
                link_valid <= 1'b0;
                link_pattern <= ~link_pattern;
            end
            if (link_done) begin
                got <= 1'b1;
                cap <= link_capture;
            end
        end
    end
endmodule // spm_link_model

// ---- verif/scan_packet_master_and_tap_tb.sv ----
// Purpose: self-checking bench of the scan packet master
// Assumes: released tdo captures as 1
// Notes: tap walks are hand-built 60-bit vectors, k-th cycle at bit 59-k
`include "spm_consts.vh"
`define CHK(g, x) begin n_compared++; if ((g) !== (x)) begin n_errors++; \
    $display("Error t=%0t got %h exp %h", $time, (g), (x)); end end
module scan_packet_master_and_tap_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, q;
    logic pready, pslverr, link_done, link_valid, scan_tck, scan_tms, scan_tdi;
    logic scan_busy, e, got, tck_d;
    logic go = 1'b0;
    logic [3:0] dly = 4'h0;
    logic [127:0] link_pattern;
    logic [63:0] link_capture, cap;
    logic [59:0] tv, dv, ev, seen_tms, seen_tdi; // tms, tdi, expected tdo, seen
    logic [31:0] idv = `SPM_IDCODE_VAL;
    logic [5:0] op = 6'h2A; // an undefined opcode
    int n_errors = 0;
    int n_compared = 0;
    int cyc = 0;
    int per = 0;
    int rises = 0;
    int div = 0;
    always #5 clk = ~clk;
    spm_master dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .link_valid(link_valid), .link_pattern(link_pattern), .link_done(link_done),
        .link_capture(link_capture), .scan_tck(scan_tck), .scan_tms(scan_tms),
        .scan_tdi(scan_tdi), .scan_busy(scan_busy));
    spm_link_model link (.clk(clk), .rst(rst), .go(go), .dly(dly),
        .pat({tv, 4'h5, dv, 4'h5}), .got(got), .cap(cap), .scan_busy(scan_busy),
        .link_done(link_done), .link_capture(link_capture), .link_valid(link_valid),
        .link_pattern(link_pattern));
    // record pins at each tck rise and check the period
    always @(negedge clk) begin
        per = per + 1;
        if (scan_busy && scan_tck && !tck_d) begin
            if (rises > 0) `CHK(per, 2 * (div + 1))
            per = 0;
            if (rises < 60) seen_tms[59 - rises] = scan_tms;
            if (rises < 60) seen_tdi[59 - rises] = scan_tdi;
            rises++;
        end
        tck_d = scan_tck;
    end
    task automatic stop_test();
        if (n_errors == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // cut a hang short
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            stop_test();
        end
    end
    // one apb transfer, held until ready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // ready, data and error are taken at the rising edge that ends the access
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // released lines show the inverse, the slave must ignore them
        paddr <= ~a;
        pwdata <= ~d;
    endtask
    // load patterns, fire by software and check the packet
    task automatic send(input int d);
        rises = 0;
        div = d;
        apb(1'b1, `SPM_OFF_CFG, 32'h0000_0070 | d);
        apb(1'b1, `SPM_OFF_TMS_UP, tv[59:28]);
        apb(1'b1, `SPM_OFF_TMS_LO, {tv[27:0], 4'hE});
        apb(1'b1, `SPM_OFF_TDI_UP, dv[59:28]);
        apb(1'b0, `SPM_OFF_TMS_LO, 32'h0000_0000);
        `CHK(q, {tv[27:0], 4'hE})
        apb(1'b1, `SPM_OFF_TDI_LO, {dv[27:0], 4'hF});
        apb(1'b0, `SPM_OFF_STAT, 32'h0000_0000);
        `CHK(q[1:0], 2'b00)
        do @(negedge clk); while (scan_busy !== 1'b0);
        `CHK(rises, 60)
        `CHK({seen_tms, seen_tdi}, {tv, dv})
        apb(1'b0, `SPM_OFF_STAT, 32'h0000_0000);
        `CHK(q[1:0], 2'b11)
        apb(1'b0, `SPM_OFF_TDO_UP, 32'h0000_0000);
        `CHK(q, ev[59:28])
        apb(1'b0, `SPM_OFF_TDO_LO, 32'h0000_0000);
        `CHK(q, {ev[27:0], 4'h0})
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        apb(1'b0, `SPM_OFF_CFG, 32'h0000_0000);
        `CHK(q, `SPM_CFG_RESET)
        apb(1'b0, `SPM_OFF_TMS_UP, 32'h0000_0000);
        `CHK(q, `SPM_PAT_RESET)
        apb(1'b0, 12'h024, 32'h0000_0000);
        `CHK({e, q}, {1'b1, 32'h0000_0000})
        // reset the tap, walk to shift-dr, read the id, park in pause-dr
        for (int k = 0; k < 60; k++) begin
            tv[59 - k] = k < 5 || k == 6 || k == 40;
            dv[59 - k] = 1'b0;
            ev[59 - k] = (k >= 9 && k <= 40) ? idv[k - 9] : 1'b1;
        end
        send(0);
        // shift an undefined opcode in, then see a one-bit bypass path
        for (int k = 0; k < 60; k++) begin
            tv[59 - k] = k < 5 || k == 6 || k == 7 || (k >= 15 && k <= 17) || k == 59;
            dv[59 - k] = (k >= 10 && k <= 15) ? op[k - 10] : k[0];
            ev[59 - k] = (k >= 10 && k <= 15) ? k == 10 : (k == 20) ? 1'b0 :
                (k > 20) ? dv[60 - k] : 1'b1;
        end
        send(2);
        // link source: software send refused, slow link offer taken
        apb(1'b1, `SPM_OFF_CFG, 32'h0000_00F1);
        rises = 0;
        div = 1;
        apb(1'b1, `SPM_OFF_TDI_LO, 32'h0000_0001);
        repeat (4) @(negedge clk);
        `CHK(scan_busy, 1'b0)
        @(posedge clk);
        go <= 1'b1;
        dly <= 4'h7;
        @(posedge clk);
        go <= 1'b0;
        do @(negedge clk); while (got !== 1'b1);
        `CHK(cap, {ev, 4'h0})
        `CHK({seen_tms, seen_tdi}, {tv, dv})
        // compliance off: tap stays in reset, so tdo is released all packet long
        rises = 0;
        div = 0;
        apb(1'b1, `SPM_OFF_CFG, 32'h0000_0060);
        apb(1'b1, `SPM_OFF_TDI_LO, 32'h0000_0001);
        do @(negedge clk); while (scan_busy !== 1'b0);
        `CHK(rises, 60)
        apb(1'b0, `SPM_OFF_TDO_LO, 32'h0000_0000);
        `CHK(q, 32'hFFFF_FFF0)
        stop_test();
    end
endmodule // scan_packet_master_and_tap_tb
bind spm_master spm_master_sva sva (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link_valid(link_valid), .link_pattern(link_pattern),
    .link_done(link_done), .link_capture(link_capture), .scan_tck(scan_tck),
    .scan_tms(scan_tms), .scan_tdi(scan_tdi), .scan_busy(scan_busy));
